//--- rtl/spf_pkg.sv
package spf_pkg;
	// Packet geometry
	localparam logic [9:0]  PKT_LAST_WORD   = 10'h3ff;
	localparam logic [9:0]  FRAME_HDR_END   = 10'h010;
	localparam logic [9:0]  CONT_HDR_END    = 10'h004;
	localparam logic [13:0] FIRST_CAPACITY  = 14'h03f0;
	localparam logic [13:0] CONT_CAPACITY   = 14'h03fc;
	localparam logic [15:0] CONT_HDR_MARK   = 16'h00a5; // Arbitrary marker value
	// Front-end block layout
	localparam logic [11:0] MAX_EVENTS      = 12'hc00;
	localparam logic [13:0] FE_HDR_WORDS    = 14'h0008;
	localparam logic [13:0] FE_HDR_VETO     = 14'h00f0;
	localparam logic [13:0] VETO_SRC_SHIFT  = 14'h0010;
	localparam logic [13:0] EVENT_SRC_BASE  = 14'h0100;
	localparam logic [13:0] BT_COUNT_IDX    = 14'h0005;
	// Header accumulation area
	localparam logic [13:0] ACC_BASE        = 14'h2800;
	localparam logic [6:0]  WINDOW_LAST     = 7'h63;
	// Quadrant header packet layout
	localparam logic [9:0]  QH_HDR_END      = 10'h028;
	localparam logic [9:0]  QH_AUX_END      = 10'h0c4;
	localparam logic [9:0]  QH_CNT_END      = 10'h0c8;
	localparam logic [9:0]  QH_ACC_END      = 10'h3e8;
	// Registers and fields
	localparam logic [11:0] REG_CTRL        = 12'h000;
	localparam logic [11:0] REG_STATUS      = 12'h004;
	localparam logic [11:0] REG_WORDS       = 12'h008;
	localparam logic [7:0]  CTRL_RESET      = 8'hf0;
	localparam logic [3:0]  CAP_OFF         = 4'hf;
	localparam int          FLG_NOVETO      = 0;
	localparam int          FLG_TWOWORD     = 1;
	localparam int          FLG_CAP         = 2;
	localparam int          CTRL_FORCE      = 3;
	// Word memory
	localparam int          RAM_AW          = 14;
	localparam int          RAM_DW          = 16;

	typedef enum logic [2:0] {K_ZERO, K_AUX, K_RAM, K_EV2, K_CONST} spf_kind_t;
	typedef enum logic [3:0] {
		ST_IDLE, ST_COPY_RD, ST_COPY_WR, ST_CNT_RD, ST_CNT_WAIT,
		ST_CALC, ST_W_A, ST_W_B, ST_W_C, ST_W_OUT
	} spf_state_t;
endpackage

//--- rtl/spf_word_ram.sv
`timescale 1ns/10ps
`default_nettype none
module spf_word_ram
	import spf_pkg::*;
(
	input  wire logic              clk_sys, // System clock
	input  wire logic              arst_n,  // Async reset, active low
	input  wire logic              we,      // Write strobe
	input  wire logic [RAM_AW-1:0] waddr,   // Write address
	input  wire logic [RAM_DW-1:0] wdata,   // Write data
	input  wire logic [RAM_AW-1:0] raddr,   // Read address
	output logic      [RAM_DW-1:0] rdata    // Registered read data
);
	logic [RAM_DW-1:0] mem [0:(1<<RAM_AW)-1];

	// Storage array, no reset so it maps onto block memory
	always_ff @(posedge clk_sys) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read data one cycle after the address
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule // spf_word_ram
`default_nettype wire

//--- rtl/spf_formatter.sv
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module spf_formatter
	import spf_pkg::*;
(
	input  wire logic        clk_sys,              // System clock, 25 MHz
	input  wire logic        arst_n,               // Async reset, active low
	input  wire logic        psel,                 // APB select
	input  wire logic        penable,              // APB enable
	input  wire logic        pwrite,               // APB write
	input  wire logic [11:0] paddr,                // APB byte address
	input  wire logic [31:0] pwdata,               // APB write data
	output logic      [31:0] prdata,               // APB read data
	output logic             pready,               // APB ready
	output logic             pslverr,              // APB error, unmapped address
	input  wire logic        fe_wr_en,             // Front-end block word write
	input  wire logic [13:0] fe_wr_addr,           // Word index within block
	input  wire logic [15:0] fe_wr_data,           // Block word
	input  wire logic        sec_tick,             // One-second boundary pulse
	input  wire logic        window_tick,          // 100-second boundary pulse
	input  wire logic [2:0]  mem_level,            // Buffer memory level
	input  wire logic        orbital_anomaly_zone, // Inside anomaly zone
	input  wire logic        in_shadow,            // Detectors in shadow
	input  wire logic        hv_off,               // Detector high voltage off
	input  wire logic        veto_off,             // Veto high voltage off
	output logic      [9:0]  aux_rd_idx,           // Packet word wanted from upstream
	output logic             aux_rd_quad,          // Word is for a quadrant packet
	input  wire logic [15:0] aux_rd_data,          // Upstream word, same cycle
	output logic             pkt_valid,            // Output word valid
	input  wire logic        pkt_ready,            // Recorder accepts word
	output logic      [15:0] pkt_data,             // Output word
	output logic             pkt_sop,              // First word of a packet
	output logic             pkt_eop               // Last word of a packet
);
	spf_state_t state_reg;
	logic [7:0]  ctrl_reg;
	logic        sec_pend_reg, win_pend_reg;
	logic        take_sec, take_win, win_clear, sec_done;
	logic [2:0]  copy_i_reg;
	logic [6:0]  slot_reg;
	logic        skipped_reg;
	logic [15:0] cnt_reg [0:3];
	logic        hdr_only, reduced;
	logic [2:0]  flags;
	logic        quad_reg, two_reg;
	logic [13:0] pre_reg, total_reg, pay_reg, ev_base_reg, calc_rem_reg;
	logic [1:0]  ev_sub_reg;
	logic [9:0]  w_reg;
	logic [3:0]  pkt_reg, needed_reg, pkt_total_reg;
	logic        cap_act_reg;
	logic [3:0]  cap_val;
	logic [11:0] events;
	logic [13:0] ev_words, calc_total;
	logic [15:0] a_reg, word_out;
	spf_kind_t   kind;
	logic [13:0] addr_a, addr_b, rem_words;
	logic [15:0] cval;
	logic        consume, at_last_word;
	logic        ram_we;
	logic [13:0] ram_waddr, ram_raddr;
	logic [15:0] ram_wdata, ram_rdata;

	// Detector idle or a full buffer leaves room for headers only
	assign hdr_only = (mem_level > 3'h1) || orbital_anomaly_zone || in_shadow || hv_off;
	assign reduced  = (mem_level == 3'h1) || ctrl_reg[CTRL_FORCE];
	assign flags    = reduced ? ctrl_reg[2:0] : 3'h0;
	assign cap_val  = ctrl_reg[7:4];

	// Ticks are held until the sequencer takes them; a new tick beats the clear
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sec_pend_reg <= 1'b0;
			win_pend_reg <= 1'b0;
		end else begin
			if (sec_tick) begin
				sec_pend_reg <= 1'b1;
			end else if (take_sec) begin
				sec_pend_reg <= 1'b0;
			end
			if (window_tick) begin
				win_pend_reg <= 1'b1;
			end else if (take_win) begin
				win_pend_reg <= 1'b0;
			end
		end
	end

	assign take_sec     = (state_reg == ST_IDLE) && sec_pend_reg;
	assign take_win     = (state_reg == ST_IDLE) && !sec_pend_reg && win_pend_reg;
	assign sec_done     = (state_reg == ST_COPY_WR) && (copy_i_reg == 3'h7);
	assign at_last_word = (w_reg == PKT_LAST_WORD);
	// Window ends at once if nothing was skipped, else after the quadrant packet
	assign win_clear = (take_win && !skipped_reg) ||
		((state_reg == ST_W_OUT) && pkt_ready && quad_reg && at_last_word);

	// Window bookkeeping: slot, skip flag and the four time counters
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			slot_reg    <= 7'h00;
			skipped_reg <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				cnt_reg[i] <= 16'h0000;
			end
		end else if (win_clear) begin
			slot_reg    <= 7'h00;
			skipped_reg <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				cnt_reg[i] <= 16'h0000;
			end
		end else if (sec_done) begin
			if (slot_reg != WINDOW_LAST) begin
				slot_reg <= slot_reg + 7'h01;
			end
			if (hdr_only) begin
				skipped_reg <= 1'b1;
			end
			// One-second mode, detector off, veto off, anomaly zone
			cnt_reg[0] <= cnt_reg[0] + {15'h0000, !hdr_only};
			cnt_reg[1] <= cnt_reg[1] + {15'h0000, hv_off};
			cnt_reg[2] <= cnt_reg[2] + {15'h0000, veto_off};
			cnt_reg[3] <= cnt_reg[3] + {15'h0000, orbital_anomaly_zone};
		end
	end

	// Event count and word total of the block now in memory
	always_comb begin
		events = (ram_rdata > {4'h0, MAX_EVENTS}) ? MAX_EVENTS : ram_rdata[11:0];
		if (flags[FLG_TWOWORD]) begin
			ev_words = {1'b0, events, 1'b0};
		end else begin
			ev_words = {1'b0, events, 1'b0} + {2'h0, events};
		end
		calc_total = ev_words + (flags[FLG_NOVETO] ? FE_HDR_WORDS : FE_HDR_VETO);
	end

	// Source of the packet word at w_reg
	always_comb begin
		kind      = K_ZERO;
		addr_a    = 14'h0000;
		addr_b    = 14'h0000;
		cval      = 16'h0000;
		consume   = 1'b0;
		rem_words = total_reg - pay_reg;
		if (quad_reg) begin
			// Quadrant packet ignores every reduced option
			if (w_reg < FRAME_HDR_END) begin
				kind = K_AUX;
			end else if (w_reg < QH_HDR_END) begin
				kind   = K_RAM;
				addr_a = {4'h0, w_reg} - {4'h0, FRAME_HDR_END};
			end else if (w_reg < QH_AUX_END) begin
				kind = K_AUX;
			end else if (w_reg < QH_CNT_END) begin
				kind = K_CONST;
				cval = cnt_reg[w_reg[1:0]];
			end else if (w_reg < QH_ACC_END) begin
				kind   = K_RAM;
				addr_a = ACC_BASE + {4'h0, w_reg} - {4'h0, QH_CNT_END};
			end
		end else if ((pkt_reg == 4'h0) && (w_reg < FRAME_HDR_END)) begin
			kind = K_AUX;
		end else if ((pkt_reg != 4'h0) && (w_reg < CONT_HDR_END)) begin
			kind = K_CONST;
			case (w_reg[1:0])
				2'h0: cval = CONT_HDR_MARK;
				2'h1: cval = {12'h000, pkt_reg};
				2'h2: cval = {12'h000, pkt_total_reg};
				default: cval = {2'h0, (rem_words > CONT_CAPACITY) ? CONT_CAPACITY : rem_words};
			endcase
		end else if (pay_reg < total_reg) begin
			consume = 1'b1;
			if (pay_reg < FE_HDR_WORDS) begin
				kind   = K_RAM;
				addr_a = pay_reg;
			end else if (pay_reg < pre_reg) begin
				kind   = K_RAM;
				addr_a = pay_reg + VETO_SRC_SHIFT; // Skips the temperature words
			end else if (two_reg) begin
				kind   = K_EV2;
				addr_a = ev_base_reg + {12'h000, ev_sub_reg};
				addr_b = addr_a + 14'h0001;
			end else begin
				kind   = K_RAM;
				addr_a = ev_base_reg + {12'h000, ev_sub_reg};
			end
		end
	end

	// Final word; three-word events are already in report layout in the block
	always_comb begin
		case (kind)
			K_AUX:   word_out = aux_rd_data;
			K_RAM:   word_out = a_reg;
			K_CONST: word_out = cval;
			K_EV2: begin
				if (ev_sub_reg == 2'h0) begin
					word_out = {a_reg[8:0], ram_rdata[15:9]};
				end else begin
					word_out = {a_reg[8:7], ram_rdata[15:8], |ram_rdata[7:1],
						ram_rdata[0], a_reg[3:0]};
				end
			end
			default: word_out = 16'h0000;
		endcase
	end

	// Sequencer: copy headers, size the frame, then stream words
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_reg     <= ST_IDLE;
			copy_i_reg    <= 3'h0;
			quad_reg      <= 1'b0;
			two_reg       <= 1'b0;
			cap_act_reg   <= 1'b0;
			pre_reg       <= FE_HDR_VETO;
			total_reg     <= 14'h0000;
			calc_rem_reg  <= 14'h0000;
			needed_reg    <= 4'h0;
			pkt_total_reg <= 4'h0;
			pay_reg       <= 14'h0000;
			ev_base_reg   <= EVENT_SRC_BASE;
			ev_sub_reg    <= 2'h0;
			w_reg         <= 10'h000;
			pkt_reg       <= 4'h0;
			a_reg         <= 16'h0000;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					w_reg   <= 10'h000;
					pkt_reg <= 4'h0;
					if (take_sec) begin
						copy_i_reg <= 3'h0;
						state_reg  <= ST_COPY_RD;
					end else if (take_win && skipped_reg) begin
						quad_reg  <= 1'b1;
						state_reg <= ST_W_A;
					end
				end
				ST_COPY_RD: begin
					state_reg <= ST_COPY_WR;
				end
				ST_COPY_WR: begin
					copy_i_reg <= copy_i_reg + 3'h1;
					if (copy_i_reg != 3'h7) begin
						state_reg <= ST_COPY_RD;
					end else if (hdr_only) begin
						state_reg <= ST_IDLE;
					end else begin
						state_reg <= ST_CNT_RD;
					end
				end
				ST_CNT_RD: begin
					state_reg <= ST_CNT_WAIT;
				end
				ST_CNT_WAIT: begin
					quad_reg    <= 1'b0;
					two_reg     <= flags[FLG_TWOWORD];
					cap_act_reg <= flags[FLG_CAP] && (cap_val != CAP_OFF);
					pre_reg     <= flags[FLG_NOVETO] ? FE_HDR_WORDS : FE_HDR_VETO;
					total_reg   <= calc_total;
					needed_reg  <= 4'h1;
					calc_rem_reg <= (calc_total > FIRST_CAPACITY) ? calc_total - FIRST_CAPACITY
						: 14'h0000;
					pay_reg     <= 14'h0000;
					ev_base_reg <= EVENT_SRC_BASE;
					ev_sub_reg  <= 2'h0;
					state_reg   <= ST_CALC;
				end
				ST_CALC: begin
					// Ceiling division by repeated subtraction, at most ten steps
					if (calc_rem_reg != 14'h0000) begin
						needed_reg   <= needed_reg + 4'h1;
						calc_rem_reg <= (calc_rem_reg > CONT_CAPACITY) ?
							calc_rem_reg - CONT_CAPACITY : 14'h0000;
					end else begin
						pkt_total_reg <= (cap_act_reg && (cap_val < needed_reg)) ?
							cap_val : needed_reg;
						state_reg <= (cap_act_reg && (cap_val == 4'h0)) ? ST_IDLE : ST_W_A;
					end
				end
				ST_W_A: begin
					state_reg <= ST_W_B;
				end
				ST_W_B: begin
					a_reg     <= ram_rdata;
					state_reg <= ST_W_C;
				end
				ST_W_C: begin
					state_reg <= ST_W_OUT;
				end
				ST_W_OUT: begin
					if (pkt_ready) begin
						state_reg <= ST_W_A;
						w_reg     <= w_reg + 10'h001;
						if (consume) begin
							pay_reg <= pay_reg + 14'h0001;
							if (pay_reg >= pre_reg) begin
								// Event source pointer walks three block words per event
								if (ev_sub_reg == (two_reg ? 2'h1 : 2'h2)) begin
									ev_sub_reg  <= 2'h0;
									ev_base_reg <= ev_base_reg + 14'h0003;
								end else begin
									ev_sub_reg <= ev_sub_reg + 2'h1;
								end
							end
						end
						if (at_last_word) begin
							pkt_reg <= pkt_reg + 4'h1;
							if (quad_reg || (pkt_reg + 4'h1 >= pkt_total_reg)) begin
								quad_reg  <= 1'b0;
								state_reg <= ST_IDLE;
							end
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Output word register; valid stands until the recorder takes it
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pkt_valid <= 1'b0;
			pkt_data  <= 16'h0000;
			pkt_sop   <= 1'b0;
			pkt_eop   <= 1'b0;
		end else if (state_reg == ST_W_C) begin
			pkt_valid <= 1'b1;
			pkt_data  <= word_out;
			pkt_sop   <= (w_reg == 10'h000);
			pkt_eop   <= at_last_word;
		end else if (pkt_ready) begin
			pkt_valid <= 1'b0;
		end
	end

	// Memory ports; header copy wins over a front-end write in the same cycle
	always_comb begin
		ram_we    = fe_wr_en;
		ram_waddr = fe_wr_addr;
		ram_wdata = fe_wr_data;
		if (state_reg == ST_COPY_WR) begin
			ram_we    = 1'b1;
			ram_waddr = ACC_BASE + {4'h0, slot_reg, copy_i_reg};
			ram_wdata = ram_rdata;
		end
		case (state_reg)
			ST_COPY_RD: ram_raddr = {11'h000, copy_i_reg};
			ST_CNT_RD:  ram_raddr = BT_COUNT_IDX;
			ST_W_B:     ram_raddr = addr_b;
			default:    ram_raddr = addr_a;
		endcase
	end

	spf_word_ram u_ram (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.we      (ram_we),
		.waddr   (ram_waddr),
		.wdata   (ram_wdata),
		.raddr   (ram_raddr),
		.rdata   (ram_rdata)
	);

	assign aux_rd_idx  = w_reg;
	assign aux_rd_quad = quad_reg;

	// APB slave; read data captured in the setup cycle so the access needs no wait
	assign pready = psel && penable;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= CTRL_RESET;
			prdata   <= 32'h00000000;
			pslverr  <= 1'b0;
		end else begin
			if (psel && !penable) begin
				pslverr <= 1'b0;
				prdata  <= 32'h00000000;
				if (paddr == REG_CTRL) begin
					prdata <= {24'h000000, ctrl_reg};
				end else if (paddr == REG_STATUS) begin
					prdata <= {20'h00000, skipped_reg, hdr_only, reduced,
						state_reg != ST_IDLE, pkt_total_reg, 1'b0, flags};
				end else if (paddr == REG_WORDS) begin
					prdata <= {18'h00000, total_reg};
				end else begin
					pslverr <= 1'b1;
				end
			end
			if (psel && penable && pwrite && (paddr == REG_CTRL)) begin
				ctrl_reg <= pwdata[7:0];
			end
		end
	end
endmodule // spf_formatter
`default_nettype wire

//--- test/spf_formatter_sva.sv
`timescale 1ns/10ps
`default_nettype none
module spf_formatter_sva
	import spf_pkg::*;
(
	input wire logic        clk_sys,     // Clock
	input wire logic        arst_n,      // Reset
	input wire logic        psel,        // APB select
	input wire logic        penable,     // APB enable
	input wire logic [11:0] paddr,       // APB address
	input wire logic [31:0] prdata,      // APB read data
	input wire logic        pready,      // APB ready
	input wire logic        pslverr,     // APB error
	input wire logic [9:0]  aux_rd_idx,  // Word index
	input wire logic        aux_rd_quad, // Quadrant packet
	input wire logic        pkt_valid,   // Word valid
	input wire logic        pkt_ready,   // Word taken
	input wire logic [15:0] pkt_data,    // Word
	input wire logic        pkt_sop,     // First word
	input wire logic        pkt_eop      // Last word
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	logic [9:0] wcnt;
	wire        acc = pkt_valid && pkt_ready;
	// Word position; wraps at 1024 since every packet has fixed length
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) wcnt <= '0;
		else if (acc) wcnt <= wcnt + 10'h001;
	end
	property p_rdy; pready == (psel && penable); endproperty
	a_rdy: assert property (p_rdy) else $error("pready not zero wait");
	property p_prd; psel && penable |=> $stable(prdata) && $stable(pslverr); endproperty
	a_prd: assert property (p_prd) else $error("read data moved after access");
	property p_err; psel && penable && paddr > REG_WORDS |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_hold;
		pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_data) && $stable(pkt_eop);
	endproperty
	a_hold: assert property (p_hold) else $error("word dropped while stalled");
	property p_sop; pkt_valid |-> pkt_sop == (wcnt == 10'h000); endproperty
	a_sop: assert property (p_sop) else $error("start marker misplaced");
	property p_eop; pkt_valid |-> pkt_eop == (wcnt == PKT_LAST_WORD); endproperty
	a_eop: assert property (p_eop) else $error("packet not 1024 words");
	property p_idx; pkt_valid |-> aux_rd_idx == wcnt; endproperty
	a_idx: assert property (p_idx) else $error("word index out of step");
	property p_qz; pkt_valid && aux_rd_quad && wcnt >= QH_ACC_END |-> pkt_data == 16'h0000;
	endproperty
	a_qz: assert property (p_qz) else $error("quadrant tail not zero");
	property p_gap; acc |=> !pkt_valid [*2]; endproperty
	a_gap: assert property (p_gap) else $error("next word too early");
	c_quad: cover property (pkt_valid && pkt_sop && aux_rd_quad);
	c_end: cover property (acc && pkt_eop);
	c_stall: cover property (pkt_valid && !pkt_ready);
	c_err: cover property (pready && pslverr);
endmodule // spf_formatter_sva
`default_nettype wire

//--- test/spf_far_end.sv
`timescale 1ns/10ps
`default_nettype none
module spf_far_end (
	input  wire logic        clk_sys,     // Clock
	input  wire logic        arst_n,      // Reset
	input  wire logic        slow,        // Recorder stalls
	input  wire logic        clr,         // Forget captured packets
	input  wire logic [9:0]  aux_rd_idx,  // Word wanted
	input  wire logic        aux_rd_quad, // Quadrant packet
	output logic      [15:0] aux_rd_data, // Upstream word
	input  wire logic        pkt_valid,   // Word valid
	output logic             pkt_ready,   // Recorder ready
	input  wire logic [15:0] pkt_data,    // Word
	input  wire logic        pkt_eop      // Last word
);
	logic [15:0] cap [0:16383];
	logic [3:0]  npkt;
	logic [9:0]  w;
	logic [2:0]  stall;
	// Frame header and status words supplied upstream, tagged by index
	assign aux_rd_data = {aux_rd_quad, 5'h00, aux_rd_idx} ^ 16'h4000;
	// Recorder drops ready two cycles in eight when slow; captures by packet
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			stall <= '0;
			pkt_ready <= 1'b0;
			npkt <= '0;
			w <= '0;
		end else begin
			stall <= stall + 3'h1;
			pkt_ready <= !slow || (stall[2:1] != 2'h3);
			if (clr) begin
				npkt <= '0;
				w <= '0;
			end else if (pkt_valid && pkt_ready) begin
				cap[{npkt, w}] <= pkt_data;
				w <= w + 10'h001;
				if (pkt_eop) npkt <= npkt + 4'h1;
			end
		end
	end
endmodule // spf_far_end
`default_nettype wire

//--- test/test_science_packet_formatter.sv
`timescale 1ns/10ps
`default_nettype none
module test_science_packet_formatter;
	import spf_pkg::*;
	logic        clk_sys, pready, pslverr, aux_rd_quad, pkt_valid, pkt_ready, pkt_sop, pkt_eop;
	logic        arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fe_wr_en = 1'b0;
	logic        sec_tick = 1'b0, window_tick = 1'b0, hv_off = 1'b0, slow = 1'b0, clr = 1'b0;
	logic        veto_off = 1'b0, in_zone = 1'b0, shadow = 1'b0;
	logic [2:0]  mem_level = 3'h0;
	logic        err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [13:0] fe_wr_addr = 14'h0000;
	logic [15:0] fe_wr_data = 16'h0000, aux_rd_data, pkt_data;
	logic [9:0]  aux_rd_idx;
	int          failures = 0, total_checks = 0, nev, tot;
	spf_formatter DUT (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fe_wr_en(fe_wr_en), .fe_wr_addr(fe_wr_addr),
		.fe_wr_data(fe_wr_data), .sec_tick(sec_tick), .window_tick(window_tick),
		.mem_level(mem_level), .orbital_anomaly_zone(in_zone), .in_shadow(shadow),
		.hv_off(hv_off), .veto_off(veto_off), .aux_rd_idx(aux_rd_idx), .aux_rd_quad(aux_rd_quad),
		.aux_rd_data(aux_rd_data), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
		.pkt_data(pkt_data), .pkt_sop(pkt_sop), .pkt_eop(pkt_eop));
	spf_far_end far (.clk_sys(clk_sys), .arst_n(arst_n), .slow(slow), .clr(clr),
		.aux_rd_idx(aux_rd_idx), .aux_rd_quad(aux_rd_quad), .aux_rd_data(aux_rd_data),
		.pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt_data(pkt_data), .pkt_eop(pkt_eop));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; holds everything until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Block word k: distinct pattern, word 5 holds the event count
	function automatic logic [15:0] blk(input int k);
		return (k == 5) ? 16'(nev) : (16'h8000 | 16'(k));
	endfunction
	// Payload word p; ofs skips temperature (and veto when dropped)
	function automatic logic [15:0] pl(input int p, input int ofs);
		if (p >= tot) return 16'h0000;
		return blk(p < 8 ? p : p + ofs);
	endfunction
	task automatic fill(input int n);
		nev = n;
		for (int k = 0; k < 256 + 3 * (n > 3072 ? 3072 : n); k++) begin
			@(posedge clk_sys);
			fe_wr_en <= 1'b1;
			fe_wr_addr <= 14'(k);
			fe_wr_data <= blk(k);
		end
		@(posedge clk_sys);
		fe_wr_en <= 1'b0;
	endtask
	// Boundary pulse, then poll busy until the sequencer settles
	task automatic second(input logic win);
		clr <= 1'b1;
		@(posedge clk_sys);
		clr <= 1'b0;
		sec_tick <= !win;
		window_tick <= win;
		@(posedge clk_sys);
		sec_tick <= 1'b0;
		window_tick <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rd = 32'h100;
		while (rd[8] !== 1'b0) apb(1'b0, REG_STATUS, 32'h0);
	endtask
	task automatic t_regs();
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rd, 32'h0000_00f0);
		apb(1'b1, 12'h00c, 32'hffff_ffff);
		chk(err, 1'b1);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h0);
		// Writes to a read-only register are dropped without an error
		apb(1'b1, REG_STATUS, 32'h0000_0fff);
		chk(err, 1'b0);
	endtask
	// Count above the event ceiling: ten packets, continuation headers checked
	task automatic t_normal();
		int np;
		int p;
		fill(3100);
		second(1'b0);
		tot = 3 * 3072 + 8 + 232;
		np = 1 + (tot - 1008 + 1019) / 1020;
		chk(far.npkt, np);
		apb(1'b0, REG_WORDS, 32'h0);
		chk(rd[13:0], tot);
		for (int w = 0; w < 16; w++) chk(far.cap[w], 16'h4000 | 16'(w));
		for (int w = 16; w < 1024; w++) chk(far.cap[w], pl(w - 16, 16));
		for (int k = 1; k < np; k++) begin
			p = 1008 + (k - 1) * 1020;
			chk(far.cap[k * 1024], CONT_HDR_MARK);
			chk(far.cap[k * 1024 + 3], (tot - p < 1020) ? tot - p : 1020);
			for (int w = 4; w < 1024; w++) chk(far.cap[k * 1024 + w], pl(p + w - 4, 248 - 232));
		end
	endtask
	// All three reduced flags with cap 1, then veto drop with cap 15, which lifts the cap
	task automatic t_reduced();
		logic [15:0] e0;
		logic [15:0] e1;
		logic [15:0] e2;
		fill(600);
		e0 = blk(256);
		e1 = blk(257);
		e2 = blk(258);
		slow <= 1'b1;
		apb(1'b1, REG_CTRL, 32'h0000_001f);
		second(1'b0);
		chk(far.npkt, 1);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd[2:0], 3'h7);
		for (int w = 16; w < 24; w++) chk(far.cap[w], blk(w - 16));
		chk(far.cap[24], {e0[8:0], e1[15:9]});
		chk(far.cap[25], {e1[8:7], e2[15:8], |e2[7:1], e2[0], e1[3:0]});
		apb(1'b1, REG_CTRL, 32'h0000_00fd);
		second(1'b0);
		chk(far.npkt, 2);
		for (int w = 24; w < 27; w++) chk(far.cap[w], blk(w + 232));
		chk(far.cap[1027], 3 * 600 + 8 - 1008);
	endtask
	// Memory level 1 status, then one header-only second per cause and the window packet
	// Recorder runs without stalls: unwritten accumulation slots read back unknown
	task automatic t_quad();
		slow <= 1'b0;
		apb(1'b1, REG_CTRL, 32'h0000_00f7);
		mem_level <= 3'h1;
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd[9], 1'b1);
		chk(rd[2:0], 3'h7);
		mem_level <= 3'h0;
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd[2:0], 3'h0);
		apb(1'b1, REG_CTRL, 32'h0000_00f0);
		second(1'b1);
		chk(far.npkt, 0);
		hv_off <= 1'b1;
		veto_off <= 1'b1;
		second(1'b0);
		chk(far.npkt, 0);
		hv_off <= 1'b0;
		veto_off <= 1'b0;
		in_zone <= 1'b1;
		second(1'b0);
		in_zone <= 1'b0;
		shadow <= 1'b1;
		second(1'b0);
		shadow <= 1'b0;
		mem_level <= 3'h2;
		second(1'b0);
		chk(far.npkt, 0);
		mem_level <= 3'h0;
		second(1'b1);
		chk(far.npkt, 1);
		for (int w = 16; w < 40; w++) chk(far.cap[w], blk(w - 16));
		chk(far.cap[40], 16'hc028);
		chk(far.cap[196], 0);
		for (int w = 197; w < 200; w++) chk(far.cap[w], 1);
		for (int w = 200; w < 232; w++) chk(far.cap[w], blk((w - 200) % 8));
		for (int w = 1000; w < 1024; w++) chk(far.cap[w], 0);
	endtask
	task automatic wrap_up();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// Watchdog at 90k cycles, above the roughly 69k cycles the tests need
	initial begin
		#3_600_000;
		failures++;
		wrap_up();
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_regs();
		t_normal();
		t_reduced();
		t_quad();
		wrap_up();
	end
endmodule // test_science_packet_formatter
bind spf_formatter spf_formatter_sva u_sva (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
	.penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.aux_rd_idx(aux_rd_idx), .aux_rd_quad(aux_rd_quad), .pkt_valid(pkt_valid),
	.pkt_ready(pkt_ready), .pkt_data(pkt_data), .pkt_sop(pkt_sop), .pkt_eop(pkt_eop));
`default_nettype wire
